// ### bench/alg_host.sv
// Host model: register port master of the sequencer
module alg_host (
  input  wire logic        clk,
  output logic      [3:0]  regAddr,
  output logic             regWrite,
  output logic      [15:0] regWrData,
  input  wire logic [15:0] regRdData
);
  timeunit 1ns;
  timeprecision 1ps;

  initial
  begin
    regAddr = 4'h0;
    regWrite = 1'b0;
    regWrData = 16'h0000;
  end

  // One-cycle write strobe, launched off the falling edge
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(negedge clk);
    regAddr = a;
    regWrData = d;
    regWrite = 1'b1;
    @(negedge clk);
    regWrite = 1'b0;
  endtask : wr

  // Read data is registered, so allow two full cycles before sampling
  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    @(negedge clk);
    regAddr = a;
    @(negedge clk);
    @(negedge clk);
    d = regRdData;
  endtask : rd
endmodule : alg_host

// ### bench/testbench.sv
// Self-checking bench for the limit, GPIO and sequencer block
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  // Short half microsecond keeps settle delays to a few hundred cycles
  localparam int HALF = 2;

  logic        clk;
  logic        resetn;
  logic [3:0]  regAddr;
  logic        regWrite;
  logic [15:0] regWrData;
  logic [15:0] regRdData;
  logic [11:0] adcData;
  logic [2:0]  adcChannel;
  logic        trackActive;
  logic        convStart;
  logic        dividerOn;
  logic        alarmIrqN;
  logic        gpioOut;
  logic        gpioOe;
  logic        benchPin;
  logic        gpioPin;
  int          failures;
  int          checked;

  // Pin level: design drives when enabled, else the outside source
  assign gpioPin = gpioOe ? gpioOut : benchPin;

  alg_sequencer #(.HALF_US_CYCLES(HALF)) u_alg_sequencer (
    .clk         (clk),
    .resetn      (resetn),
    .regAddr     (regAddr),
    .regWrite    (regWrite),
    .regWrData   (regWrData),
    .regRdData   (regRdData),
    .adcData     (adcData),
    .adcChannel  (adcChannel),
    .trackActive (trackActive),
    .convStart   (convStart),
    .dividerOn   (dividerOn),
    .alarmIrqN   (alarmIrqN),
    .gpioIn      (gpioPin),
    .gpioOut     (gpioOut),
    .gpioOe      (gpioOe)
  );

  alg_host u_alg_host (
    .clk       (clk),
    .regAddr   (regAddr),
    .regWrite  (regWrite),
    .regWrData (regWrData),
    .regRdData (regRdData)
  );

  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
    checked++;
    if (seen !== exp)
    begin
      failures++;
      $display("Error at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask : check

  task automatic rdchk(input logic [3:0] a, input logic [15:0] exp, input string what);
    logic [15:0] d;
    u_alg_host.rd(a, d);
    check(d, exp, what);
  endtask : rdchk

  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", checked, failures);
    if (failures == 0 && checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : finish_test

  // Single conversion; counts tracking cycles, starts and divider misuse
  task automatic convert(input logic [2:0] ch, input logic [1:0] rank,
                         input int samples, input int trackHalf);
    int trackN;
    int startN;
    int divBad;
    trackN = 0;
    startN = 0;
    divBad = 0;
    u_alg_host.wr(alg_pkg::ADDR_CTRL_TWO, 16'h4000 | (16'(rank) << 5));
    u_alg_host.wr(alg_pkg::ADDR_CTRL_ONE, 16'h8400 | (16'(ch) << 12));
    repeat (3000)
    begin
      @(negedge clk);
      trackN += int'(trackActive === 1'b1);
      startN += int'(convStart === 1'b1);
      if (dividerOn !== (trackActive && ch == alg_pkg::CH_CELL)
          || (trackActive === 1'b1 && adcChannel !== ch))
        divBad++;
    end
    check(16'(trackN), 16'(samples * trackHalf * HALF), "track cycles");
    check(16'(startN), 16'(samples), "conversion starts");
    check(16'(divBad), 16'h0000, "divider cycles");
  endtask : convert

  // Aux then battery in sequence mode; period taken between first conversions
  task automatic test_sequence;
    int cyc;
    int t1;
    int n;
    int divN;
    int period;
    int inSpan;
    cyc = 0;
    t1 = 0;
    n = 0;
    divN = 0;
    period = (2 * alg_pkg::SETTLE_UNIT_HALF_US + 2 * (4 + alg_pkg::SAR_CYCLE_HALF_US)
              + alg_pkg::GAP_UNIT_HALF_US) * HALF;
    adcData = 12'h020;
    u_alg_host.wr(alg_pkg::ADDR_LIMIT_STAT, 16'hC80C);
    u_alg_host.wr(alg_pkg::ADDR_CTRL_TWO, 16'h4000);
    u_alg_host.wr(alg_pkg::ADDR_CTRL_ONE, 16'h8801);
    while (n < 3 && cyc < 4000)
    begin
      @(negedge clk);
      cyc++;
      divN += int'(dividerOn === 1'b1 && n > 0);
      if (convStart === 1'b1)
      begin
        n++;
        if (n == 1)
        begin
          t1 = cyc;
          check(16'(adcChannel), 16'(alg_pkg::CH_AUX), "first sequence channel");
        end
        if (n == 2)
          check(16'(adcChannel), 16'(alg_pkg::CH_CELL), "second sequence channel");
      end
    end
    // A few cycles of state overhead per period are allowed
    inSpan = int'((cyc - t1) >= period && (cyc - t1) <= period + 16);
    check(16'(n), 16'h0003, "sequence conversions");
    check(16'(divN), 16'(4 * HALF), "sequence divider cycles");
    check(16'(inSpan), 16'h0001, "sequence period");
    u_alg_host.wr(alg_pkg::ADDR_CTRL_ONE, 16'h8000);
    repeat (1300) @(negedge clk);
    rdchk(alg_pkg::ADDR_RESULT, 16'h0020, "sequence result");
    rdchk(alg_pkg::ADDR_LIMIT_STAT, 16'h480C, "sequence status");
    check(16'(alarmIrqN), 16'h0001, "low source masked");
  endtask : test_sequence

  task automatic test_reset;
    rdchk(alg_pkg::ADDR_CTRL_ONE, 16'h0000, "ctrl one reset");
    rdchk(alg_pkg::ADDR_CTRL_TWO, 16'h4040, "ctrl two reset");
    rdchk(alg_pkg::ADDR_LIMIT_STAT, 16'h0000, "ctrl three reset");
    rdchk(alg_pkg::ADDR_UPPER, 16'h0000, "upper reset");
    rdchk(alg_pkg::ADDR_LOWER, 16'h0000, "lower reset");
    u_alg_host.wr(alg_pkg::ADDR_RESULT, 16'h0ABC);
    rdchk(alg_pkg::ADDR_RESULT, 16'h0000, "result read only");
    rdchk(4'h0, 16'h0000, "unmapped read");
  endtask : test_reset

  task automatic test_limits;
    u_alg_host.wr(alg_pkg::ADDR_UPPER, 16'h0800);
    u_alg_host.wr(alg_pkg::ADDR_LOWER, 16'h0100);
    u_alg_host.wr(alg_pkg::ADDR_LIMIT_STAT, 16'h0C00);
    adcData = 12'h050;
    convert(alg_pkg::CH_CELL, 2'h0, 1, 4);
    rdchk(alg_pkg::ADDR_RESULT, 16'h0050, "cell result");
    rdchk(alg_pkg::ADDR_LIMIT_STAT, 16'h4C00, "low status");
    check(16'(alarmIrqN), 16'h0000, "low alarm");
    u_alg_host.wr(alg_pkg::ADDR_LIMIT_STAT, 16'h4C00);
    rdchk(alg_pkg::ADDR_LIMIT_STAT, 16'h0C00, "status cleared");
    check(16'(alarmIrqN), 16'h0001, "alarm cleared");
    adcData = 12'h900;
    convert(alg_pkg::CH_AUX, 2'h1, 4, 4);
    rdchk(alg_pkg::ADDR_RESULT, 16'h0900, "aux result");
    rdchk(alg_pkg::ADDR_LIMIT_STAT, 16'h8C00, "high status");
    // Clear status and drop both enables, then exceed again
    u_alg_host.wr(alg_pkg::ADDR_LIMIT_STAT, 16'hC000);
    convert(alg_pkg::CH_AUX, 2'h3, 16, 4);
    check(16'(alarmIrqN), 16'h0001, "masked alarm");
  endtask : test_limits

  task automatic test_temp;
    convert(alg_pkg::CH_TEMP, 2'h0, 1, 32);
    rdchk(alg_pkg::ADDR_RESULT, 16'h0900, "temp not stored");
  endtask : test_temp

  task automatic test_gpio;
    u_alg_host.wr(alg_pkg::ADDR_CTRL_ONE, 16'h8000);
    u_alg_host.wr(alg_pkg::ADDR_CTRL_TWO, 16'h3400);
    repeat (2) @(negedge clk);
    check(16'({gpioOe, gpioOut}), 16'h0003, "output high");
    u_alg_host.wr(alg_pkg::ADDR_CTRL_TWO, 16'h3000);
    repeat (2) @(negedge clk);
    check(16'({gpioOe, gpioOut}), 16'h0002, "output inverted");
    u_alg_host.wr(alg_pkg::ADDR_CTRL_TWO, 16'h1400);
    repeat (2) @(negedge clk);
    check(16'(gpioOe), 16'h0000, "pin analog");
    benchPin = 1'b1;
    u_alg_host.wr(alg_pkg::ADDR_CTRL_TWO, 16'h2C00);
    repeat (6) @(negedge clk);
    rdchk(alg_pkg::ADDR_CTRL_TWO, 16'h3C00, "input high");
    check(16'(alarmIrqN), 16'h0000, "gpio alarm");
    u_alg_host.wr(alg_pkg::ADDR_LIMIT_STAT, 16'h1000);
    repeat (3) @(negedge clk);
    check(16'(alarmIrqN), 16'h0001, "gpio blocked");
    u_alg_host.wr(alg_pkg::ADDR_LIMIT_STAT, 16'h0000);
    repeat (3) @(negedge clk);
    check(16'(alarmIrqN), 16'h0000, "gpio unblocked");
    benchPin = 1'b0;
    repeat (6) @(negedge clk);
    check(16'(alarmIrqN), 16'h0001, "pin change clears");
    // Data written as 0 must not stick while the pin is an input
    u_alg_host.wr(alg_pkg::ADDR_CTRL_TWO, 16'h2800);
    repeat (6) @(negedge clk);
    rdchk(alg_pkg::ADDR_CTRL_TWO, 16'h3800, "input inverted");
    u_alg_host.wr(alg_pkg::ADDR_CTRL_TWO, 16'h3400);
    repeat (6) @(negedge clk);
    check(16'(alarmIrqN), 16'h0001, "no alarm as output");
  endtask : test_gpio

  initial
  begin
    resetn = 1'b0;
    benchPin = 1'b0;
    adcData = 12'h000;
    failures = 0;
    checked = 0;
    repeat (16) @(negedge clk);
    resetn = 1'b1;
    test_reset();
    test_limits();
    test_temp();
    test_sequence();
    test_gpio();
    finish_test();
  end

  // Tests need about 15k cycles; allow plenty of margin
  initial
  begin
    repeat (60000) @(posedge clk);
    failures++;
    finish_test();
  end
endmodule : testbench

// ### rtl/alg_pkg.sv
// Constants for the auxiliary, limit, GPIO and sequencer block
// How it works
// R1: Battery input scaled by four while sampled
// R2: Divider powered only during battery sampling
// R3: Code 010 is battery, result at 0x0C
// R4: Aux and battery results checked against limits
// R5: Separate high and low status bits set
// R6: Out-of-limit result drives alarm pin when enabled
// R7: Cleared enable bit masks that limit source
// R8: Bit 13 enables GPIO, else bits ignored
// R9: GPIO data lives in bit 12
// R10: Bit 11 picks output or read-only input
// R11: Bit 10 clear inverts both directions
// R12: Bit 12 of third register blocks GPIO alarm
// R13: GPIO alarm only from input with data set
// R14: GPIO alarm holds until pin or enable changes
// R15: Settle delay before every screen channel
// R16: One opening delay if no screen channel; closing delay
// R17: Track time, conversion and sort per measurement
// R18: Temperature always uses 16 us tracking
// R19: No sort time when rank window off
// R20: Samples per channel follow rank window
// R21: Period is channels, closing delay and gap
// R22: Bits 6:5 give 1, 4, 8 or 16 samples
// R23: Code 011 is aux, shares result register
// R24: High above limit, low below limit
// R25: Intervals from one timebase; gap after closing delay
package alg_pkg;
  localparam logic [3:0]  ADDR_CTRL_ONE    = 4'h1;
  localparam logic [3:0]  ADDR_CTRL_TWO    = 4'h2;
  localparam logic [3:0]  ADDR_LIMIT_STAT  = 4'h3;
  localparam logic [3:0]  ADDR_UPPER       = 4'h4;
  localparam logic [3:0]  ADDR_LOWER       = 4'h5;
  localparam logic [3:0]  ADDR_RESULT      = 4'hC;
  localparam logic [3:0]  ADDR_IDENT       = 4'hE;
  localparam logic [15:0] RST_CTRL_ONE     = 16'h0000;
  localparam logic [15:0] RST_CTRL_TWO     = 16'h4040;
  localparam logic [15:0] RST_ZERO         = 16'h0000;
  // Control one fields
  localparam int          C1_INT_EN        = 15;
  localparam int          C1_CHAN_LSB      = 12;
  localparam int          C1_MODE_LSB      = 10;
  localparam int          C1_TRACK_LSB     = 8;
  localparam int          C1_GAP_LSB       = 0;
  // Control two fields
  localparam int          C2_GPIO_EN       = 13;
  localparam int          C2_GPIO_DATA     = 12;
  localparam int          C2_GPIO_DIR      = 11;
  localparam int          C2_PIN_SENSE     = 10;
  localparam int          C2_RANK_LSB      = 5;
  localparam int          C2_SETTLE_LSB    = 0;
  // Limit status and mask fields
  localparam int          C3_HIGH_STAT     = 15;
  localparam int          C3_LOW_STAT      = 14;
  localparam int          C3_GPIO_BLOCK    = 12;
  localparam int          C3_HIGH_EN       = 11;
  localparam int          C3_LOW_EN        = 10;
  localparam logic [1:0]  MODE_OFF         = 2'h0;
  localparam logic [1:0]  MODE_SINGLE      = 2'h1;
  localparam logic [1:0]  MODE_SEQUENCE    = 2'h2;
  localparam logic [2:0]  CH_TEMP          = 3'h1;
  localparam logic [2:0]  CH_CELL          = 3'h2;
  localparam logic [2:0]  CH_AUX           = 3'h3;
  localparam logic [2:0]  CH_SCREEN_MIN    = 3'h4;
  // Times in half microseconds, then the clock and half-microsecond timebase
  localparam int          SAR_CYCLE_HALF_US = 15;
  localparam int          SORT_HALF_US      = 4;
  localparam int          TEMP_TRACK_HALF_US = 32;
  localparam int          SETTLE_UNIT_HALF_US = 256;
  localparam int          GAP_UNIT_HALF_US  = 74;
  localparam int          CLK_MHZ           = 125;
  localparam int          HALF_US_NS        = 500;
  localparam int          HALF_US_CYCLES    = (HALF_US_NS * CLK_MHZ + 999) / 1000;
  // Arbitrary value, names no real part
  localparam logic [15:0] IDENT_CODE        = 16'h0A5C;
endpackage : alg_pkg

// ### rtl/alg_sequencer.sv
// Register file, limit check, GPIO and conversion sequencer
module alg_sequencer #(
  parameter int HALF_US_CYCLES = alg_pkg::HALF_US_CYCLES,
  parameter int DATA_WIDTH     = 12
) (
  input  wire logic                  clk,
  input  wire logic                  resetn,
  input  wire logic [3:0]            regAddr,
  input  wire logic                  regWrite,
  input  wire logic [15:0]           regWrData,
  output logic      [15:0]           regRdData,
  input  wire logic [DATA_WIDTH-1:0] adcData,
  output logic      [2:0]            adcChannel,
  output logic                       trackActive,
  output logic                       convStart,
  output logic                       dividerOn,
  output logic                       alarmIrqN,
  input  wire logic                  gpioIn,
  output logic                       gpioOut,
  output logic                       gpioOe
);
  if (HALF_US_CYCLES < 1 || HALF_US_CYCLES > 255 || DATA_WIDTH > 12 || DATA_WIDTH < 1)
  begin : g_bad_param
    $error("alg_sequencer: unsupported parameter value");
  end

  typedef enum logic [2:0] {
    S_IDLE, S_PICK, S_SETTLE, S_TRACK, S_CONVERT, S_SORT, S_NEXT, S_STORE
  } alg_state_t;
  // Closing delay and gap reuse the settle and sort states via flags
  typedef enum logic [1:0] {
    P_CHANNEL, P_CLOSE, P_GAP
  } alg_phase_t;

  logic [15:0]  ctrlOne;
  logic [15:0]  ctrlTwo;
  logic [15:0]  limitStat;
  logic [15:0]  upperLimit;
  logic [15:0]  lowerLimit;
  logic [15:0]  monResult;
  logic         pinMeta;
  logic         pinSync;
  logic         pinLast;
  logic         gpioEnLast;
  logic         gpioAlarm;
  logic         singleDone;
  alg_state_t   state;
  alg_state_t   next_state;
  alg_phase_t   phase;
  alg_phase_t   next_phase;
  logic [23:0]  segCount;
  logic [23:0]  next_segCount;
  logic [7:0]   remaining;
  logic [7:0]   next_remaining;
  logic [2:0]   channel;
  logic [2:0]   next_channel;
  logic         firstChannel;
  logic [4:0]   sampleLeft;
  logic [15:0]  accum;
  logic         storeMon;

  wire logic       gpioEn    = ctrlTwo[alg_pkg::C2_GPIO_EN];
  wire logic       gpioDir   = ctrlTwo[alg_pkg::C2_GPIO_DIR];
  wire logic       pinSense  = ctrlTwo[alg_pkg::C2_PIN_SENSE];
  wire logic [1:0] rankSize  = ctrlTwo[alg_pkg::C2_RANK_LSB +: 2];
  wire logic [1:0] mode      = ctrlOne[alg_pkg::C1_MODE_LSB +: 2];
  wire logic       segDone   = (segCount == 24'h00_0000);

  function automatic logic [23:0] alg_cycles(input int halfUs);
    int c;
    c = halfUs * HALF_US_CYCLES;
    return (c < 1) ? 24'h00_0000 : 24'(c - 1);
  endfunction : alg_cycles

  function automatic logic [2:0] alg_top_channel(input logic [7:0] mask);
    logic [2:0] r;
    r = 3'h0;
    for (int i = 1; i < 8; i++)
      if (mask[i])
        r = 3'(i);
    return r;
  endfunction : alg_top_channel

  // 1, 4, 8 or 16 samples
  function automatic logic [4:0] alg_samples(input logic [1:0] code);
    unique case (code)
      2'h0: return 5'h01;
      2'h1: return 5'h04;
      2'h2: return 5'h08;
      2'h3: return 5'h10;
    endcase
  endfunction : alg_samples

  function automatic int alg_track_half_us(input logic [2:0] ch, input logic [1:0] code);
    if (ch == alg_pkg::CH_TEMP)
      return alg_pkg::TEMP_TRACK_HALF_US; // R18
    return 4 << code; // R17
  endfunction : alg_track_half_us

  // Register writes; limit status is write-one-to-clear with set winning
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      ctrlOne    <= alg_pkg::RST_CTRL_ONE;
      upperLimit <= alg_pkg::RST_ZERO;
      lowerLimit <= alg_pkg::RST_ZERO;
    end
    else if (regWrite)
    begin
      if (regAddr == alg_pkg::ADDR_CTRL_ONE)
        ctrlOne <= regWrData;
      if (regAddr == alg_pkg::ADDR_UPPER)
        upperLimit <= regWrData; // R4
      if (regAddr == alg_pkg::ADDR_LOWER)
        lowerLimit <= regWrData; // R4
    end
  end

  always_ff @(posedge clk)
  begin
    if (!resetn)
      ctrlTwo <= alg_pkg::RST_CTRL_TWO;
    else
    begin
      if (regWrite && regAddr == alg_pkg::ADDR_CTRL_TWO)
      begin
        ctrlTwo <= regWrData;
        // Data bit is read-only while an enabled input
        if (gpioEn && gpioDir && regWrData[alg_pkg::C2_GPIO_EN] && regWrData[alg_pkg::C2_GPIO_DIR])
          ctrlTwo[alg_pkg::C2_GPIO_DATA] <= ctrlTwo[alg_pkg::C2_GPIO_DATA]; // R10
      end
      else if (gpioEn && gpioDir)
        ctrlTwo[alg_pkg::C2_GPIO_DATA] <= pinSense ? pinSync : ~pinSync; // R10 R11
    end
  end

  always_ff @(posedge clk)
  begin
    if (!resetn)
      limitStat <= alg_pkg::RST_ZERO;
    else
    begin
      if (regWrite && regAddr == alg_pkg::ADDR_LIMIT_STAT)
      begin
        limitStat[13:0] <= regWrData[13:0];
        if (regWrData[alg_pkg::C3_HIGH_STAT])
          limitStat[alg_pkg::C3_HIGH_STAT] <= 1'b0;
        if (regWrData[alg_pkg::C3_LOW_STAT])
          limitStat[alg_pkg::C3_LOW_STAT] <= 1'b0;
      end
      // Set after clear so a same-cycle event survives
      if (storeMon && monResult > upperLimit)
        limitStat[alg_pkg::C3_HIGH_STAT] <= 1'b1; // R5 R24
      if (storeMon && monResult < lowerLimit)
        limitStat[alg_pkg::C3_LOW_STAT] <= 1'b1; // R5 R24
    end
  end

  always_ff @(posedge clk)
  begin
    if (!resetn)
      regRdData <= 16'h0000;
    else
    begin
      unique case (regAddr)
        alg_pkg::ADDR_CTRL_ONE:   regRdData <= ctrlOne;
        alg_pkg::ADDR_CTRL_TWO:   regRdData <= ctrlTwo;
        alg_pkg::ADDR_LIMIT_STAT: regRdData <= limitStat;
        alg_pkg::ADDR_UPPER:      regRdData <= upperLimit;
        alg_pkg::ADDR_LOWER:      regRdData <= lowerLimit;
        alg_pkg::ADDR_RESULT:     regRdData <= monResult; // R3 R23
        alg_pkg::ADDR_IDENT:      regRdData <= alg_pkg::IDENT_CODE;
        default:                  regRdData <= 16'h0000;
      endcase
    end
  end

  // Pin synchroniser
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      pinMeta <= 1'b0;
      pinSync <= 1'b0;
      pinLast <= 1'b0;
      gpioEnLast <= 1'b0;
    end
    else
    begin
      pinMeta <= gpioIn;
      pinSync <= pinMeta;
      pinLast <= pinSync;
      gpioEnLast <= gpioEn;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      gpioOut <= 1'b0;
      gpioOe  <= 1'b0;
    end
    else
    begin
      gpioOe  <= gpioEn && !gpioDir; // R8 R10
      gpioOut <= pinSense ? ctrlTwo[alg_pkg::C2_GPIO_DATA] : ~ctrlTwo[alg_pkg::C2_GPIO_DATA]; // R11
    end
  end

  // GPIO alarm latch: cleared by a pin or enable change, or while bit 11 selects output
  always_ff @(posedge clk)
  begin
    if (!resetn)
      gpioAlarm <= 1'b0;
    else if (pinSync != pinLast || gpioEn != gpioEnLast)
      gpioAlarm <= 1'b0; // R14
    else if (!gpioDir)
      gpioAlarm <= 1'b0; // R13
    else if (gpioEn && gpioDir && ctrlTwo[alg_pkg::C2_GPIO_DATA]
             && !limitStat[alg_pkg::C3_GPIO_BLOCK])
      gpioAlarm <= 1'b1; // R12 R13
  end

  always_ff @(posedge clk)
  begin
    if (!resetn)
      alarmIrqN <= 1'b1;
    else
      alarmIrqN <= !(ctrlOne[alg_pkg::C1_INT_EN]
        && ((limitStat[alg_pkg::C3_HIGH_STAT] && limitStat[alg_pkg::C3_HIGH_EN])
        || (limitStat[alg_pkg::C3_LOW_STAT] && limitStat[alg_pkg::C3_LOW_EN])
        || (gpioAlarm && !limitStat[alg_pkg::C3_GPIO_BLOCK]))); // R6 R7 R12
  end

  // Sequencer next state
  always_comb
  begin
    next_state     = state;
    next_phase     = phase;
    next_segCount  = segDone ? segCount : segCount - 24'h00_0001;
    next_remaining = remaining;
    next_channel   = channel;
    unique case (state)
      S_IDLE:
      begin
        next_phase = P_CHANNEL;
        if (mode == alg_pkg::MODE_SEQUENCE)
        begin
          next_remaining = {limitStat[7:1], 1'b0};
          next_state = S_PICK;
        end
        else if (mode == alg_pkg::MODE_SINGLE && !singleDone)
        begin
          next_remaining = 8'(1) << ctrlOne[alg_pkg::C1_CHAN_LSB +: 3];
          next_state = S_PICK;
        end
      end
      S_PICK:
      begin
        if (next_remaining == 8'h00 || remaining == 8'h00)
        begin
          next_phase = P_CLOSE;
          next_state = S_SETTLE;
          next_segCount = alg_cycles(alg_pkg::SETTLE_UNIT_HALF_US
            * (int'(ctrlTwo[alg_pkg::C2_SETTLE_LSB +: 4]) + 1)); // R16
        end
        else
        begin
          next_channel = alg_top_channel(remaining);
          next_remaining = remaining & ~(8'(1) << next_channel);
          if (next_channel >= alg_pkg::CH_SCREEN_MIN || firstChannel)
          begin
            next_state = S_SETTLE; // R15 R16
            next_segCount = alg_cycles(alg_pkg::SETTLE_UNIT_HALF_US
              * (int'(ctrlTwo[alg_pkg::C2_SETTLE_LSB +: 4]) + 1));
          end
          else
          begin
            next_state = S_TRACK;
            next_segCount = alg_cycles(alg_track_half_us(next_channel,
              ctrlOne[alg_pkg::C1_TRACK_LSB +: 2]));
          end
        end
      end
      S_SETTLE:
        if (segDone)
        begin
          if (phase == P_CLOSE && mode == alg_pkg::MODE_SEQUENCE)
          begin
            next_phase = P_GAP; // R21 R25
            next_state = S_SORT;
            next_segCount = alg_cycles(alg_pkg::GAP_UNIT_HALF_US
              * int'(ctrlOne[alg_pkg::C1_GAP_LSB +: 8]));
          end
          else if (phase == P_CLOSE)
            next_state = S_IDLE;
          else
          begin
            next_state = S_TRACK;
            next_segCount = alg_cycles(alg_track_half_us(channel,
              ctrlOne[alg_pkg::C1_TRACK_LSB +: 2]));
          end
        end
      S_TRACK:
        if (segDone)
        begin
          next_state = S_CONVERT;
          next_segCount = alg_cycles(alg_pkg::SAR_CYCLE_HALF_US); // R17
        end
      S_CONVERT:
        if (segDone)
        begin
          if (rankSize != 2'h0)
          begin
            next_state = S_SORT;
            next_segCount = alg_cycles(alg_pkg::SORT_HALF_US); // R17
          end
          else
            next_state = S_NEXT; // R19
        end
      S_SORT:
        if (segDone)
          next_state = (phase == P_GAP) ? S_IDLE : S_NEXT;
      S_NEXT:
        if (sampleLeft == 5'h00)
          next_state = S_STORE;
        else
        begin
          next_state = S_TRACK; // R20
          next_segCount = alg_cycles(alg_track_half_us(channel,
            ctrlOne[alg_pkg::C1_TRACK_LSB +: 2]));
        end
      S_STORE:
        next_state = S_PICK;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      state     <= S_IDLE;
      phase     <= P_CHANNEL;
      segCount  <= 24'h00_0000;
      remaining <= 8'h00;
      channel   <= 3'h0;
    end
    else
    begin
      state     <= next_state;
      phase     <= next_phase;
      segCount  <= next_segCount;
      remaining <= next_remaining;
      channel   <= next_channel;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!resetn)
      firstChannel <= 1'b0;
    else if (state == S_IDLE)
      firstChannel <= 1'b1;
    else if (state == S_PICK)
      firstChannel <= 1'b0;
  end

  // One-shot mode rearms on any write to control one
  always_ff @(posedge clk)
  begin
    if (!resetn)
      singleDone <= 1'b0;
    else if (regWrite && regAddr == alg_pkg::ADDR_CTRL_ONE)
      singleDone <= 1'b0;
    else if (state == S_PICK && mode == alg_pkg::MODE_SINGLE)
      singleDone <= 1'b1;
  end

  // Samples are averaged, not ranked: sort time is modelled only
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      sampleLeft <= 5'h00;
      accum      <= 16'h0000;
    end
    else if (state == S_PICK)
    begin
      sampleLeft <= alg_samples(rankSize) - 5'h01; // R20 R22
      accum      <= 16'h0000;
    end
    else if (state == S_CONVERT && segDone)
      accum <= accum + 16'(adcData);
    else if (state == S_NEXT && sampleLeft != 5'h00)
      sampleLeft <= sampleLeft - 5'h01;
  end

  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      monResult <= alg_pkg::RST_ZERO;
      storeMon  <= 1'b0;
    end
    else
    begin
      storeMon <= 1'b0;
      if (state == S_STORE && (channel == alg_pkg::CH_CELL || channel == alg_pkg::CH_AUX))
      begin
        monResult <= accum >> (rankSize == 2'h0 ? 0 : int'(rankSize) + 1); // R3 R23
        storeMon  <= 1'b1; // R4
      end
    end
  end

  // Analog controls follow the next state so they align with it
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      trackActive <= 1'b0;
      convStart   <= 1'b0;
      dividerOn   <= 1'b0;
      adcChannel  <= 3'h0;
    end
    else
    begin
      trackActive <= next_state == S_TRACK;
      convStart   <= next_state == S_CONVERT && state != S_CONVERT;
      dividerOn   <= next_state == S_TRACK && next_channel == alg_pkg::CH_CELL; // R1 R2
      adcChannel  <= next_channel;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  chk_divider_only_cell: assert property (dividerOn |-> trackActive && adcChannel == alg_pkg::CH_CELL) // R2
    else $error("divider on outside battery tracking");
  chk_divider_during_cell: assert property (trackActive && adcChannel == alg_pkg::CH_CELL |-> dividerOn) // R1
    else $error("battery tracked without divider");
  chk_gpio_pin_drive: assert property (gpioOe |-> $past(gpioEn) && !$past(gpioDir)) // R8
    else $error("pin driven while not an enabled output");
  chk_gpio_polarity: assert property (gpioOe && $past(gpioOe) |-> gpioOut == ($past(pinSense) ? $past(ctrlTwo[alg_pkg::C2_GPIO_DATA]) : !$past(ctrlTwo[alg_pkg::C2_GPIO_DATA]))) // R11
    else $error("pin level does not follow data and sense");
  chk_gpio_alarm_input: assert property (gpioAlarm |-> $past(gpioDir) && $past(gpioEn)) // R13
    else $error("gpio alarm without input mode");
  chk_high_stat_set: assert property (storeMon && monResult > upperLimit |=> limitStat[alg_pkg::C3_HIGH_STAT]) // R24
    else $error("high status missed");
  chk_low_stat_set: assert property (storeMon && monResult < lowerLimit |=> limitStat[alg_pkg::C3_LOW_STAT]) // R24
    else $error("low status missed");
  chk_alarm_masked: assert property (!limitStat[alg_pkg::C3_HIGH_EN] && !limitStat[alg_pkg::C3_LOW_EN] && !gpioAlarm |=> alarmIrqN) // R7
    else $error("masked source raised alarm");
  chk_sort_skip: assert property (state == S_SORT && phase != P_GAP |-> rankSize != 2'h0) // R19
    else $error("sort time with rank window off");
  chk_conv_pulse: assert property (convStart |=> !convStart ##1 !trackActive) // R17
    else $error("conversion start longer than one cycle");

  cov_cell_store: cover property (storeMon && channel == alg_pkg::CH_CELL);
  cov_gpio_alarm: cover property (gpioAlarm && !alarmIrqN);
  cov_gap_phase: cover property (state == S_SORT && phase == P_GAP);
endmodule : alg_sequencer
